//--- rtl/uirqg_pkg.sv
`default_nettype none
package uirqg_pkg;
   localparam int          ADDR_W        = 32;
   localparam int          DATA_W        = 32;
   localparam int          IRQ_N         = 16;
   localparam int          RAM_WORDS     = 256;
   localparam int          RAM_AW        = 8;
   localparam logic [11:0] OFF_SCRATCH   = 12'h000;
   localparam logic [11:0] OFF_MEMSIZE   = 12'h004;
   localparam logic [11:0] OFF_IRQCTRL   = 12'h008;
   localparam logic [11:0] OFF_IRQSTAT   = 12'h00C;
   localparam logic [ADDR_W-1:0] RAM_BASE = 32'h0000_1000;
   localparam logic [ADDR_W-1:0] RAM_MASK = 32'hFFFF_FC00;
   localparam int          SIZE_EXP_LSB  = 4;
   localparam int          SIZE_UNIT_LSB = 0;
   localparam logic [3:0]  SIZE_EXP      = 4'h0;
   localparam logic [3:0]  UNIT_BYTE     = 4'h0;
   localparam logic [3:0]  UNIT_KB       = 4'h1;
   localparam logic [3:0]  UNIT_MB       = 4'h2;
   localparam logic [3:0]  UNIT_GB       = 4'h3;
   localparam logic [3:0]  SIZE_UNIT     = UNIT_KB;
   localparam logic [31:0] SCRATCH_RST   = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RESP = 2'b01,
      ST_RDWT = 2'b11
   } uirqg_bus_type;
endpackage : uirqg_pkg
`default_nettype wire

//--- rtl/uirqg_ram_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uirqg_ram_if;
   import uirqg_pkg::*;
   logic                  wrEn;
   logic [RAM_AW-1:0]     addr;
   logic [DATA_W-1:0]     wrData;
   logic [DATA_W/8-1:0]   wrStrb;
   logic [DATA_W-1:0]     rdData;
   modport master (output wrEn, output addr, output wrData, output wrStrb,
                   input rdData);
   modport slave (input wrEn, input addr, input wrData, input wrStrb,
                  output rdData);
endinterface : uirqg_ram_if
`default_nettype wire

//--- rtl/uirqg_ram.sv
`timescale 1ns/1ps
`default_nettype none
module uirqg_ram
   import uirqg_pkg::*;
(
   input  wire logic      sys_clk,
   uirqg_ram_if.slave     ramPort
);
   // Array without reset so that it maps onto block RAM.
   logic [DATA_W-1:0] mem [RAM_WORDS];
   logic [DATA_W-1:0] rdWord_ff;

   always_ff @(posedge sys_clk)
   begin
      for (int b = 0; b < DATA_W/8; b++)
      begin
         if (ramPort.wrEn && ramPort.wrStrb[b])
         begin
            mem[ramPort.addr][8*b +: 8] <= ramPort.wrData[8*b +: 8];
         end
      end
      rdWord_ff <= mem[ramPort.addr];
   end

   assign ramPort.rdData = rdWord_ff;
endmodule : uirqg_ram
`default_nettype wire

//--- rtl/uirqg_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Size bits 7:4 give exponent n.
// RULE2: Size bits 3:0 give unit code.
// RULE3: Writing one at 0x08 raises interrupt.
// RULE4: Host requests only while status reads one.
// RULE5: Status 0x0C reads zero while in progress.
// RULE6: Host clears control bit after service.
// RULE7: Control bit stays set until host clears.
// RULE8: Same port reaches 1K block RAM.
// RULE9: Scratch at 0x00 reads back writes.
// RULE10: Control bit drives request until acknowledged.
module uirqg_top
   import uirqg_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   input  wire logic [ADDR_W-1:0]    s_axil_awaddr,
   input  wire logic                 s_axil_awvalid,
   output logic                      s_axil_awready,
   input  wire logic [DATA_W-1:0]    s_axil_wdata,
   input  wire logic [DATA_W/8-1:0]  s_axil_wstrb,
   input  wire logic                 s_axil_wvalid,
   output logic                      s_axil_wready,
   output logic [1:0]                s_axil_bresp,
   output logic                      s_axil_bvalid,
   input  wire logic                 s_axil_bready,
   input  wire logic [ADDR_W-1:0]    s_axil_araddr,
   input  wire logic                 s_axil_arvalid,
   output logic                      s_axil_arready,
   output logic [DATA_W-1:0]         s_axil_rdata,
   output logic [1:0]                s_axil_rresp,
   output logic                      s_axil_rvalid,
   input  wire logic                 s_axil_rready,
   output logic [IRQ_N-1:0]          usrIrqReq,
   input  wire logic [IRQ_N-1:0]     usrIrqAck
);
   typedef struct packed {
      uirqg_bus_type       wrSt;
      uirqg_bus_type       rdSt;
      logic                awReady;
      logic                wReady;
      logic                arReady;
      logic [1:0]          bResp;
      logic                bValid;
      logic [DATA_W-1:0]   rData;
      logic [1:0]          rResp;
      logic                rValid;
      logic [DATA_W-1:0]   scratch;
      logic [IRQ_N-1:0]    ctrl;
      logic [IRQ_N-1:0]    busy;
      logic [IRQ_N-1:0]    req;
   } uirqg_state_type;

   uirqg_state_type state_ff;
   uirqg_state_type nxt_state;
   uirqg_ram_if     ramBus ();

   function automatic logic isRam(input logic [ADDR_W-1:0] a);
      return (a & RAM_MASK) == RAM_BASE;
   endfunction : isRam

   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0]   old,
      input logic [DATA_W-1:0]   wd,
      input logic [DATA_W/8-1:0] st);
      logic [DATA_W-1:0] r;
      r = old;
      for (int b = 0; b < DATA_W/8; b++)
      begin
         if (st[b])
         begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // RULE8: RAM on port.
   uirqg_ram u_ram (
      .sys_clk (sys_clk),
      .ramPort (ramBus.slave)
   );

   logic             wrFire;
   logic             rdFire;
   logic [IRQ_N-1:0] wrCtrl;
   logic [11:0]      wOff;
   logic [11:0]      rOff;
   logic [DATA_W-1:0] ctrlMerged;

   assign wrFire = s_axil_awvalid && s_axil_wvalid && state_ff.wrSt == ST_IDLE;
   assign rdFire = s_axil_arvalid && state_ff.rdSt == ST_IDLE && !wrFire;
   assign wOff   = s_axil_awaddr[11:0];
   assign rOff   = s_axil_araddr[11:0];
   // Widen the control bits so the byte-lane merge can be shared.
   assign ctrlMerged = merge({{(DATA_W-IRQ_N){1'b0}}, state_ff.ctrl},
                             s_axil_wdata, s_axil_wstrb);
   assign wrCtrl     = ctrlMerged[IRQ_N-1:0];

   // Writes take priority on the shared RAM address; reads wait a cycle.
   assign ramBus.wrEn   = wrFire && isRam(s_axil_awaddr);
   assign ramBus.addr   = wrFire ? s_axil_awaddr[RAM_AW+1:2]
                                 : s_axil_araddr[RAM_AW+1:2];
   assign ramBus.wrData = s_axil_wdata;
   assign ramBus.wrStrb = s_axil_wstrb;

   always_comb
   begin
      nxt_state         = state_ff;
      nxt_state.awReady = 1'b0;
      nxt_state.wReady  = 1'b0;
      nxt_state.arReady = 1'b0;
      // RULE10: request until ack.
      nxt_state.req  = state_ff.req & ~usrIrqAck;
      nxt_state.busy = state_ff.busy & ~usrIrqAck;

      unique case (state_ff.wrSt)
         ST_IDLE:
         begin
            if (wrFire)
            begin
               nxt_state.awReady = 1'b1;
               nxt_state.wReady  = 1'b1;
               nxt_state.bValid  = 1'b1;
               nxt_state.bResp   = RESP_OKAY;
               nxt_state.wrSt    = ST_RESP;
               if (isRam(s_axil_awaddr))
               begin
                  nxt_state.bResp = RESP_OKAY;
               end
               else if (wOff == OFF_SCRATCH && s_axil_awaddr[31:12] == '0)
               begin
                  // RULE9: scratch write.
                  nxt_state.scratch = merge(state_ff.scratch, s_axil_wdata,
                                            s_axil_wstrb);
               end
               else if (wOff == OFF_IRQCTRL && s_axil_awaddr[31:12] == '0)
               begin
                  // RULE7: bit held until cleared.
                  nxt_state.ctrl = wrCtrl;
                  // RULE3: rising bit raises interrupt.
                  // RULE4: only ready bits start.
                  nxt_state.req  = nxt_state.req |
                                   (wrCtrl & ~state_ff.ctrl & ~state_ff.busy);
                  // RULE5: in progress reads zero.
                  nxt_state.busy = nxt_state.busy |
                                   (wrCtrl & ~state_ff.ctrl & ~state_ff.busy);
               end
               else if (!(wOff == OFF_MEMSIZE || wOff == OFF_IRQSTAT)
                        || s_axil_awaddr[31:12] != '0)
               begin
                  nxt_state.bResp = RESP_SLVERR;
               end
            end
         end
         ST_RESP:
         begin
            if (s_axil_bready)
            begin
               nxt_state.bValid = 1'b0;
               nxt_state.wrSt   = ST_IDLE;
            end
         end
         default:
         begin
            nxt_state.wrSt = ST_IDLE;
         end
      endcase

      unique case (state_ff.rdSt)
         ST_IDLE:
         begin
            if (rdFire)
            begin
               nxt_state.arReady = 1'b1;
               nxt_state.rResp   = RESP_OKAY;
               nxt_state.rData   = '0;
               if (isRam(s_axil_araddr))
               begin
                  // RULE8: RAM read wait.
                  nxt_state.rdSt  = ST_RDWT;
               end
               else
               begin
                  nxt_state.rValid = 1'b1;
                  nxt_state.rdSt   = ST_RESP;
                  if (s_axil_araddr[31:12] != '0)
                  begin
                     nxt_state.rResp = RESP_SLVERR;
                  end
                  else
                  begin
                     unique case (rOff)
                        OFF_SCRATCH: nxt_state.rData = state_ff.scratch;
                        OFF_MEMSIZE:
                        begin
                           // RULE1: exponent field.
                           nxt_state.rData[SIZE_EXP_LSB +: 4]  = SIZE_EXP;
                           // RULE2: unit field.
                           nxt_state.rData[SIZE_UNIT_LSB +: 4] = SIZE_UNIT;
                        end
                        OFF_IRQCTRL: nxt_state.rData[IRQ_N-1:0] =
                           state_ff.ctrl;
                        // RULE5: ready flags.
                        OFF_IRQSTAT: nxt_state.rData[IRQ_N-1:0] =
                           ~state_ff.busy;
                        default: nxt_state.rResp = RESP_SLVERR;
                     endcase
                  end
               end
            end
         end
         ST_RDWT:
         begin
            nxt_state.rData  = ramBus.rdData;
            nxt_state.rValid = 1'b1;
            nxt_state.rdSt   = ST_RESP;
         end
         ST_RESP:
         begin
            if (s_axil_rready)
            begin
               nxt_state.rValid = 1'b0;
               nxt_state.rdSt   = ST_IDLE;
            end
         end
         default:
         begin
            nxt_state.rdSt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff         <= '0;
         state_ff.wrSt    <= ST_IDLE;
         state_ff.rdSt    <= ST_IDLE;
         state_ff.scratch <= SCRATCH_RST;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign s_axil_awready = state_ff.awReady;
   assign s_axil_wready  = state_ff.wReady;
   assign s_axil_bresp   = state_ff.bResp;
   assign s_axil_bvalid  = state_ff.bValid;
   assign s_axil_arready = state_ff.arReady;
   assign s_axil_rdata   = state_ff.rData;
   assign s_axil_rresp   = state_ff.rResp;
   assign s_axil_rvalid  = state_ff.rValid;
   assign usrIrqReq      = state_ff.req;
endmodule : uirqg_top
`default_nettype wire

//--- verif/uirqg_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module uirqg_monitor
   import uirqg_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              resetn,
   input wire logic              s_axil_awvalid,
   input wire logic              s_axil_awready,
   input wire logic              s_axil_wvalid,
   input wire logic              s_axil_wready,
   input wire logic              s_axil_bvalid,
   input wire logic              s_axil_bready,
   input wire logic              s_axil_arvalid,
   input wire logic              s_axil_arready,
   input wire logic              s_axil_rvalid,
   input wire logic              s_axil_rready,
   input wire logic [DATA_W-1:0] s_axil_rdata,
   input wire logic [1:0]        s_axil_rresp,
   input wire logic [IRQ_N-1:0]  usrIrqReq,
   input wire logic [IRQ_N-1:0]  usrIrqAck
);
   logic [IRQ_N-1:0] reqPrev_ff;
   logic [IRQ_N-1:0] ackPrev_ff;
   logic             wrTake;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // A write wins the edge, so a read is only taken when no write is.
   assign wrTake = s_axil_awvalid && s_axil_wvalid && !s_axil_bvalid
                   && !s_axil_awready;
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
      begin
         reqPrev_ff <= '0;
         ackPrev_ff <= '0;
      end
      else
      begin
         reqPrev_ff <= usrIrqReq;
         ackPrev_ff <= usrIrqAck;
      end
   sequence s_rdTake;
      s_axil_arvalid && !s_axil_arready && !s_axil_rvalid && !wrTake;
   endsequence
   sequence s_rdAnswer;
      s_axil_arready ##[0:1] s_axil_rvalid;
   endsequence
   a_write_answer: assert property (
      wrTake |=> s_axil_awready && s_axil_wready && s_axil_bvalid)
      else $error("write not answered in one cycle");
   a_read_answer: assert property (s_rdTake |=> s_rdAnswer)
      else $error("read not answered in time");
   a_bvalid_holds: assert property (
      s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
      else $error("write response dropped early");
   a_rdata_holds: assert property (
      s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid
         && $stable(s_axil_rdata))
      else $error("read data changed while waiting");
   a_ready_pulse: assert property (
      s_axil_awready |=> !s_axil_awready && !s_axil_wready)
      else $error("address ready longer than one cycle");
   a_slverr_zero: assert property (
      s_axil_rvalid && s_axil_rresp == RESP_SLVERR |-> s_axil_rdata == '0)
      else $error("error read returned data");
   a_req_cause: assert property (
      (usrIrqReq & ~$past(usrIrqReq)) != '0 |-> $rose(s_axil_bvalid))
      else $error("request raised without a write");
   a_ack_clears: assert property (
      (reqPrev_ff & ackPrev_ff & usrIrqReq) == '0)
      else $error("request kept after acknowledge");
   a_req_holds: assert property (
      (reqPrev_ff & ~ackPrev_ff & ~usrIrqReq) == '0)
      else $error("request dropped without acknowledge");
endmodule : uirqg_monitor
bind uirqg_top uirqg_monitor u_mon (.sys_clk(sys_clk), .resetn(resetn),
   .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
   .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
   .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
   .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
   .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
   .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
   .usrIrqReq(usrIrqReq), .usrIrqAck(usrIrqAck));
`default_nettype wire

//--- verif/uirqg_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module uirqg_core_model
   import uirqg_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic [7:0]       ackLag,
   input  wire logic [IRQ_N-1:0] usrIrqReq,
   output logic [IRQ_N-1:0]      usrIrqAck
);
   logic [7:0] waitCnt_ff;
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
      begin
         waitCnt_ff <= 8'h00;
         usrIrqAck  <= '0;
      end
      else
      begin
         usrIrqAck <= '0;
         // Restarting after an acknowledge stops a second pulse in flight.
         if (usrIrqReq == '0 || usrIrqAck != '0)
            waitCnt_ff <= 8'h00;
         else if (waitCnt_ff >= ackLag)
            usrIrqAck <= usrIrqReq;
         else
            waitCnt_ff <= waitCnt_ff + 8'h01;
      end
endmodule : uirqg_core_model
`default_nettype wire

//--- verif/tb_user_irq_generator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_user_irq_generator;
   import uirqg_pkg::*;
   logic              sys_clk, resetn, awValid, wValid, bReady, arValid;
   logic              rReady, awReady, wReady, bValid, arReady, rValid;
   logic [ADDR_W-1:0] awAddr, arAddr;
   logic [DATA_W-1:0] wData, rData, d, m;
   logic [DATA_W-1:0] v [3];
   logic [3:0]        wStrb;
   logic [1:0]        bResp, rResp;
   logic [IRQ_N-1:0]  irqReq, irqAck;
   logic [7:0]        ackLag;
   logic [33:0]       bQ [$];
   logic [33:0]       rQ [$];
   int                seed = 94944;
   int                fail_count = 0;
   int                comparisons = 0;
   uirqg_top u_dut (.sys_clk(sys_clk), .resetn(resetn),
      .s_axil_awaddr(awAddr), .s_axil_awvalid(awValid),
      .s_axil_awready(awReady), .s_axil_wdata(wData), .s_axil_wstrb(wStrb),
      .s_axil_wvalid(wValid), .s_axil_wready(wReady), .s_axil_bresp(bResp),
      .s_axil_bvalid(bValid), .s_axil_bready(bReady),
      .s_axil_araddr(arAddr), .s_axil_arvalid(arValid),
      .s_axil_arready(arReady), .s_axil_rdata(rData), .s_axil_rresp(rResp),
      .s_axil_rvalid(rValid), .s_axil_rready(rReady),
      .usrIrqReq(irqReq), .usrIrqAck(irqAck));
   uirqg_core_model u_core (.sys_clk(sys_clk), .resetn(resetn),
      .ackLag(ackLag), .usrIrqReq(irqReq), .usrIrqAck(irqAck));
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] x,
                     input logic [3:0] s, input logic [1:0] r);
      int n;
      bQ.push_back({r, 32'h0});
      @(negedge sys_clk);
      {awAddr, wData, wStrb, awValid, wValid} <= {a, x, s, 2'b11};
      n = 0;
      for (n = 0; n < 40 && awReady !== 1'b1; n++)
         @(negedge sys_clk);
      @(negedge sys_clk);
      {awValid, wValid} <= 2'b00;
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [33:0] e);
      int n;
      rQ.push_back(e);
      @(negedge sys_clk);
      {arAddr, arValid} <= {a, 1'b1};
      n = 0;
      for (n = 0; n < 40 && arReady !== 1'b1; n++)
         @(negedge sys_clk);
      @(negedge sys_clk);
      arValid <= 1'b0;
   endtask : rd
   task automatic wrap_up;
      if (bQ.size() != 0 || rQ.size() != 0)
         fail_count++;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Random response stalls make the slave hold its answers.
   always @(negedge sys_clk)
      {bReady, rReady} <= 2'($random(seed));
   always @(posedge sys_clk)
   begin
      if (bValid === 1'b1 && bReady === 1'b1)
         chk({bResp, 32'h0}, bQ.pop_front());
      if (rValid === 1'b1 && rReady === 1'b1)
         chk({rResp, rData}, rQ.pop_front());
   end
   initial
   begin
      #50000;
      fail_count++;
      wrap_up();
   end
   initial
   begin
      {resetn, awValid, wValid, arValid} = '0;
      {awAddr, arAddr, wData, wStrb, ackLag} = '0;
      repeat (8) @(negedge sys_clk);
      resetn = 1'b1;
      rd(32'(OFF_SCRATCH), {RESP_OKAY, SCRATCH_RST});
      rd(32'(OFF_MEMSIZE), {RESP_OKAY, 24'h0, SIZE_EXP, SIZE_UNIT});
      rd(32'(OFF_IRQCTRL), {RESP_OKAY, 32'h0});
      rd(32'(OFF_IRQSTAT), {RESP_OKAY, 16'h0, 16'hFFFF});
      $display("reset values done");
      d = $random(seed);
      wr(32'(OFF_SCRATCH), d, 4'hF, RESP_OKAY);
      wr(32'(OFF_SCRATCH), ~d, 4'h2, RESP_OKAY);
      rd(32'(OFF_SCRATCH), {RESP_OKAY, d[31:16], ~d[15:8], d[7:0]});
      wr(32'(OFF_MEMSIZE), d, 4'hF, RESP_OKAY);
      wr(32'(OFF_IRQSTAT), d, 4'hF, RESP_OKAY);
      rd(32'(OFF_MEMSIZE), {RESP_OKAY, 24'h0, SIZE_EXP, SIZE_UNIT});
      rd(32'(OFF_IRQSTAT), {RESP_OKAY, 16'h0, 16'hFFFF});
      wr(32'h0000_0010, d, 4'hF, RESP_SLVERR);
      rd(32'h0000_0010, {RESP_SLVERR, 32'h0});
      $display("registers done");
      foreach (v[i])
      begin
         v[i] = $random(seed);
         wr(RAM_BASE + 32'(i * 508), v[i], 4'hF, RESP_OKAY);
      end
      foreach (v[i])
         rd(RAM_BASE + 32'(i * 508), {RESP_OKAY, v[i]});
      rd(RAM_BASE + 32'h400, {RESP_SLVERR, 32'h0});
      $display("memory done");
      for (int b = 0; b < IRQ_N; b++)
      begin
         ackLag = b[0] ? 8'h00 : 8'h14;
         m = 32'h1 << b;
         wr(32'(OFF_IRQCTRL), m, 4'hF, RESP_OKAY);
         chk({18'h0, irqReq}, {2'h0, m});
         if (!b[0])
            rd(32'(OFF_IRQSTAT), {RESP_OKAY, 16'h0, ~m[15:0]});
         repeat (30) @(negedge sys_clk);
         rd(32'(OFF_IRQSTAT), {RESP_OKAY, 16'h0, 16'hFFFF});
         rd(32'(OFF_IRQCTRL), {RESP_OKAY, m});
         wr(32'(OFF_IRQCTRL), 32'h0, 4'hF, RESP_OKAY);
      end
      $display("interrupts done");
      repeat (20) @(negedge sys_clk);
      wrap_up();
   end
endmodule : tb_user_irq_generator
`default_nettype wire
